// ==== include/irq_flag_bank_cfg.svh ====
/*
  constants of the interrupt flag bank: register offsets, implemented-bit
  masks, reset values and flag bit positions.
  assumes a byte-addressed 8-bit register port carrying 16-bit data.
*/
`ifndef IRQ_FLAG_BANK_CFG_SVH
`define IRQ_FLAG_BANK_CFG_SVH

// register offsets
`define OFS_FLAGS0 8'h00
`define OFS_FLAGS1 8'h04
`define OFS_FLAGS2 8'h08
`define OFS_ENABLE0 8'h0c
`define OFS_ENABLE1 8'h10
`define OFS_ENABLE2 8'h14
`define OFS_POLARITY 8'h18
`define OFS_PENDING 8'h1c

// implemented bits of each flag (and enable) register and of the polarity register
`define IMPL_FLAGS0 16'hbfef
`define IMPL_FLAGS1 16'hfa1f
`define IMPL_FLAGS2 16'h0023
`define IMPL_POLARITY 16'h0007

// reset values
`define RST_FLAGS 16'h0000
`define RST_ENABLE 16'h0000
`define RST_POLARITY 16'h0000

// flag register 0 positions
`define BIT_MEMORY_OP_DONE 15
`define BIT_CONVERSION_DONE 13
`define BIT_SERIAL_A_TX 12
`define BIT_SERIAL_A_RX 11
`define BIT_SYNC_SERIAL_A_EVENT 10
`define BIT_SYNC_SERIAL_A_FAULT 9
`define BIT_TIMER_C 8
`define BIT_TIMER_B 7
`define BIT_COMPARE_CH_B 6
`define BIT_CAPTURE_CH_B 5
`define BIT_TIMER_A 3
`define BIT_COMPARE_CH_A 2
`define BIT_CAPTURE_CH_A 1
`define BIT_EXT_PIN_A 0

// flag register 1 positions
`define BIT_SERIAL_B_TX 15
`define BIT_SERIAL_B_RX 14
`define BIT_EXT_PIN_C 13
`define BIT_TIMER_E 12
`define BIT_TIMER_D 11
`define BIT_COMPARE_CH_C 9
`define BIT_EXT_PIN_B 4
`define BIT_PIN_CHANGE 3
`define BIT_COMPARATOR 2
`define BIT_TWO_WIRE_A_MASTER 1
`define BIT_TWO_WIRE_A_SLAVE 0

// flag register 2 positions
`define BIT_CAPTURE_CH_C 5
`define BIT_SYNC_SERIAL_B_EVENT 1
`define BIT_SYNC_SERIAL_B_FAULT 0

// polarity register positions
`define BIT_EXT_PIN_A_POLARITY 0
`define BIT_EXT_PIN_B_POLARITY 1
`define BIT_EXT_PIN_C_POLARITY 2

`endif

// ==== include/irq_flag_bank_pkg.sv ====
/*
  types shared by the interrupt flag bank.
  assumes irq_flag_bank_cfg.svh supplies the numeric constants.
*/
package irq_flag_bank_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [47:0] flag_vec_t;
endpackage

// ==== logic/edge_catch.sv ====
/*
  edge catcher: optional synchroniser, then one pulse per selected edge.
  assumes level_i is synchronous when STAGES is 0, asynchronous otherwise.
*/
`timescale 1ns/100ps
module edge_catch #(
  parameter int STAGES = 0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic level_i,
  input wire logic falling_i,
  output logic pulse_o
);
  wire [STAGES:0] pipe;
  logic prev;
  wire level = pipe[STAGES];

  generate
    if (STAGES == 1) begin : g_bad
      $error("edge_catch: STAGES must be 0 or at least 2");
    end
    if (STAGES > 1) begin : g_sync
      logic [STAGES-1:0] stage;
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          stage <= '0;
        end else begin
          stage <= {stage[STAGES-2:0], level_i};
        end
      end
      assign pipe[STAGES:1] = stage;
    end
  endgenerate

  assign pipe[0] = level_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign pulse_o = falling_i ? (prev & ~level) : (level & ~prev);
endmodule

// ==== logic/interrupt_flag_status_bank.sv ====
/*
  interrupt flag status bank: three 16-bit flag registers set by peripheral
  and external-pin events, with enable and polarity registers and one
  level interrupt request.
  assumes peripheral request lines run on clk_i; external pins are
  asynchronous; the register master never issues read and write together.
*/
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "irq_flag_bank_cfg.svh"
module interrupt_flag_status_bank
  import irq_flag_bank_pkg::*;
#(
  parameter int PIN_SYNC_STAGES = 2
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // peripheral request lines
  input wire logic memory_op_done_i,
  input wire logic conversion_done_i,
  input wire logic serial_a_tx_i,
  input wire logic serial_a_rx_i,
  input wire logic sync_serial_a_event_i,
  input wire logic sync_serial_a_fault_i,
  input wire logic timer_c_i,
  input wire logic timer_b_i,
  input wire logic compare_ch_b_i,
  input wire logic capture_ch_b_i,
  input wire logic timer_a_i,
  input wire logic compare_ch_a_i,
  input wire logic capture_ch_a_i,
  input wire logic serial_b_tx_i,
  input wire logic serial_b_rx_i,
  input wire logic timer_e_i,
  input wire logic timer_d_i,
  input wire logic compare_ch_c_i,
  input wire logic pin_change_i,
  input wire logic comparator_i,
  input wire logic two_wire_a_master_i,
  input wire logic two_wire_a_slave_i,
  input wire logic capture_ch_c_i,
  input wire logic sync_serial_b_event_i,
  input wire logic sync_serial_b_fault_i,
  // external interrupt pins
  input wire logic ext_pin_a_i,
  input wire logic ext_pin_b_i,
  input wire logic ext_pin_c_i,
  // towards priority and vectoring logic
  output logic [47:0] pending_o,
  output logic irq_o
);
  localparam flag_vec_t IMPL = {`IMPL_FLAGS2, `IMPL_FLAGS1, `IMPL_FLAGS0};
  localparam int PIN_A = `BIT_EXT_PIN_A;
  localparam int PIN_B = 16 + `BIT_EXT_PIN_B;
  localparam int PIN_C = 16 + `BIT_EXT_PIN_C;

  generate
    if (PIN_SYNC_STAGES < 2) begin : g_bad_sync
      $error("interrupt_flag_status_bank: PIN_SYNC_STAGES below 2");
    end
    if (!IMPL[PIN_A] || !IMPL[PIN_B] || !IMPL[PIN_C]) begin : g_bad_pins
      $error("interrupt_flag_status_bank: pin flags outside implemented bits");
    end
  endgenerate

  // register state
  reg_word_t flags0;
  reg_word_t flags1;
  reg_word_t flags2;
  reg_word_t enable0;
  reg_word_t enable1;
  reg_word_t enable2;
  reg_word_t polarity;

  reg_word_t next_flags0;
  reg_word_t next_flags1;
  reg_word_t next_flags2;

  // set path from the request lines
  reg_word_t req0;
  reg_word_t req1;
  reg_word_t req2;

  flag_vec_t req_vec;
  flag_vec_t src_pulse;
  flag_vec_t set_vec;
  flag_vec_t flag_vec;
  flag_vec_t enable_vec;

  logic pin_a_pulse;
  logic pin_b_pulse;
  logic pin_c_pulse;

  // address decode
  wire hit_flags0 = (addr_i == `OFS_FLAGS0);
  wire hit_flags1 = (addr_i == `OFS_FLAGS1);
  wire hit_flags2 = (addr_i == `OFS_FLAGS2);
  wire hit_enable0 = (addr_i == `OFS_ENABLE0);
  wire hit_enable1 = (addr_i == `OFS_ENABLE1);
  wire hit_enable2 = (addr_i == `OFS_ENABLE2);
  wire hit_polarity = (addr_i == `OFS_POLARITY);
  wire hit_pending = (addr_i == `OFS_PENDING);

  // register write strobes
  wire wr_flags0 = wr_i & hit_flags0;
  wire wr_flags1 = wr_i & hit_flags1;
  wire wr_flags2 = wr_i & hit_flags2;
  wire wr_enable0 = wr_i & hit_enable0;
  wire wr_enable1 = wr_i & hit_enable1;
  wire wr_enable2 = wr_i & hit_enable2;
  wire wr_polarity = wr_i & hit_polarity;

  // gather request lines at their flag positions
  always_comb begin
    req0 = '0;
    req0[`BIT_MEMORY_OP_DONE] = memory_op_done_i;
    req0[`BIT_CONVERSION_DONE] = conversion_done_i;
    req0[`BIT_SERIAL_A_TX] = serial_a_tx_i;
    req0[`BIT_SERIAL_A_RX] = serial_a_rx_i;
    req0[`BIT_SYNC_SERIAL_A_EVENT] = sync_serial_a_event_i;
    req0[`BIT_SYNC_SERIAL_A_FAULT] = sync_serial_a_fault_i;
    req0[`BIT_TIMER_C] = timer_c_i;
    req0[`BIT_TIMER_B] = timer_b_i;
    req0[`BIT_COMPARE_CH_B] = compare_ch_b_i;
    req0[`BIT_CAPTURE_CH_B] = capture_ch_b_i;
    req0[`BIT_TIMER_A] = timer_a_i;
    req0[`BIT_COMPARE_CH_A] = compare_ch_a_i;
    req0[`BIT_CAPTURE_CH_A] = capture_ch_a_i;
  end

  always_comb begin
    req1 = '0;
    req1[`BIT_SERIAL_B_TX] = serial_b_tx_i;
    req1[`BIT_SERIAL_B_RX] = serial_b_rx_i;
    req1[`BIT_TIMER_E] = timer_e_i;
    req1[`BIT_TIMER_D] = timer_d_i;
    req1[`BIT_COMPARE_CH_C] = compare_ch_c_i;
    req1[`BIT_PIN_CHANGE] = pin_change_i;
    req1[`BIT_COMPARATOR] = comparator_i;
    req1[`BIT_TWO_WIRE_A_MASTER] = two_wire_a_master_i;
    req1[`BIT_TWO_WIRE_A_SLAVE] = two_wire_a_slave_i;
  end

  always_comb begin
    req2 = '0;
    req2[`BIT_CAPTURE_CH_C] = capture_ch_c_i;
    req2[`BIT_SYNC_SERIAL_B_EVENT] = sync_serial_b_event_i;
    req2[`BIT_SYNC_SERIAL_B_FAULT] = sync_serial_b_fault_i;
  end

  assign req_vec = {req2, req1, req0};

  // one rising-edge catcher per implemented peripheral source
  // history resets low, so a line already high at release counts as one event
  genvar g;
  generate
    for (g = 0; g < 48; g++) begin : g_src
      if (IMPL[g] && g != PIN_A && g != PIN_B && g != PIN_C) begin : g_edge
        edge_catch #(
          .STAGES(0)
        ) u_src (
          .clk_i(clk_i),
          .nrst_i(nrst_i),
          .level_i(req_vec[g]),
          .falling_i(1'b0),
          .pulse_o(src_pulse[g])
        );
      end else begin : g_none
        assign src_pulse[g] = 1'b0;
      end
    end
  endgenerate

  // external pins: synchronised, edge chosen by polarity
  edge_catch #(
    .STAGES(PIN_SYNC_STAGES)
  ) u_pin_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(ext_pin_a_i),
    .falling_i(polarity[`BIT_EXT_PIN_A_POLARITY]),
    .pulse_o(pin_a_pulse)
  );

  edge_catch #(
    .STAGES(PIN_SYNC_STAGES)
  ) u_pin_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(ext_pin_b_i),
    .falling_i(polarity[`BIT_EXT_PIN_B_POLARITY]),
    .pulse_o(pin_b_pulse)
  );

  edge_catch #(
    .STAGES(PIN_SYNC_STAGES)
  ) u_pin_c (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(ext_pin_c_i),
    .falling_i(polarity[`BIT_EXT_PIN_C_POLARITY]),
    .pulse_o(pin_c_pulse)
  );

  // pins take their own slots in the set vector
  always_comb begin
    set_vec = src_pulse;
    set_vec[PIN_A] = pin_a_pulse;
    set_vec[PIN_B] = pin_b_pulse;
    set_vec[PIN_C] = pin_c_pulse;
    set_vec = set_vec & IMPL;
  end

  // software value applies, then hardware sets win over a written 0
  wire reg_word_t sw_flags0 = wr_flags0 ? wdata_i : flags0;
  wire reg_word_t sw_flags1 = wr_flags1 ? wdata_i : flags1;
  wire reg_word_t sw_flags2 = wr_flags2 ? wdata_i : flags2;
  wire reg_word_t hw_set0 = set_vec[15:0];
  wire reg_word_t hw_set1 = set_vec[31:16];
  wire reg_word_t hw_set2 = set_vec[47:32];

  assign next_flags0 = (sw_flags0 | hw_set0) & `IMPL_FLAGS0;
  assign next_flags1 = (sw_flags1 | hw_set1) & `IMPL_FLAGS1;
  assign next_flags2 = (sw_flags2 | hw_set2) & `IMPL_FLAGS2;

  // flag registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags0 <= `RST_FLAGS;
    end else begin
      flags0 <= next_flags0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags1 <= `RST_FLAGS;
    end else begin
      flags1 <= next_flags1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags2 <= `RST_FLAGS;
    end else begin
      flags2 <= next_flags2;
    end
  end

  // enable and polarity registers, written by software only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable0 <= `RST_ENABLE;
    end else if (wr_enable0) begin
      enable0 <= wdata_i & `IMPL_FLAGS0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable1 <= `RST_ENABLE;
    end else if (wr_enable1) begin
      enable1 <= wdata_i & `IMPL_FLAGS1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable2 <= `RST_ENABLE;
    end else if (wr_enable2) begin
      enable2 <= wdata_i & `IMPL_FLAGS2;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      polarity <= `RST_POLARITY;
    end else if (wr_polarity) begin
      polarity <= wdata_i & `IMPL_POLARITY;
    end
  end

  // flag and enable words seen by the vectoring logic

  assign flag_vec = {flags2, flags1, flags0};
  assign enable_vec = {enable2, enable1, enable0};
  assign pending_o = flag_vec & enable_vec;
  assign irq_o = |pending_o;

  // summary register: bit 0 mirrors the request line
  wire reg_word_t summary = {15'h0, irq_o};

  // read mux, unmapped addresses read zero
  reg_word_t rd_mux;
  always_comb begin
    if (hit_flags0) begin
      rd_mux = flags0;
    end else if (hit_flags1) begin
      rd_mux = flags1;
    end else if (hit_flags2) begin
      rd_mux = flags2;
    end else if (hit_enable0) begin
      rd_mux = enable0;
    end else if (hit_enable1) begin
      rd_mux = enable1;
    end else if (hit_enable2) begin
      rd_mux = enable2;
    end else if (hit_polarity) begin
      rd_mux = polarity;
    end else if (hit_pending) begin
      rd_mux = summary;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // read data stand only in the cycle after the strobe
  wire reg_word_t rd_next = rd_i ? rd_mux : 16'h0000;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_next;
    end
  end
endmodule

// ==== verif/flag_bank_properties.sv ====
/* assertions on the flag bank's ports.
   assumes the bank's offsets and masks come from its cfg header. */
`timescale 1ns/100ps
`include "irq_flag_bank_cfg.svh"
module flag_bank_properties (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic timer_a_i,
  input wire logic [47:0] pending_o,
  input wire logic irq_o
);
  logic [15:0] last_w;
  wire w0 = wr_i && addr_i == `OFS_FLAGS0;
  wire r0 = rd_i && addr_i == `OFS_FLAGS0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_w <= 16'h0000;
    end else if (w0) begin
      last_w <= wdata_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_irq_level;
    irq_o == (pending_o != 48'h0);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq differs from pending");
  property p_reset_clear;
    $rose(nrst_i) |-> pending_o == 48'h0 && !irq_o && rdata_o == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
  property p_flags0_gaps;
    r0 |=> (rdata_o & ~`IMPL_FLAGS0) == 16'h0000;
  endproperty
  a_flags0_gaps: assert property (p_flags0_gaps) else $error("flags0 empty bit set");
  property p_flags1_gaps;
    rd_i && addr_i == `OFS_FLAGS1 |=> (rdata_o & ~`IMPL_FLAGS1) == 16'h0000;
  endproperty
  a_flags1_gaps: assert property (p_flags1_gaps) else $error("flags1 empty bit set");
  property p_flags2_gaps;
    rd_i && addr_i == `OFS_FLAGS2 |=> (rdata_o & ~`IMPL_FLAGS2) == 16'h0000;
  endproperty
  a_flags2_gaps: assert property (p_flags2_gaps) else $error("flags2 empty bit set");
  property p_write_set;
    w0 ##[1:2] r0 |=> (rdata_o & last_w) == (last_w & `IMPL_FLAGS0);
  endproperty
  a_write_set: assert property (p_write_set) else $error("written one not set");
  property p_hw_set;
    $rose(timer_a_i) ##1 !w0 ##1 r0 |=> rdata_o[3];
  endproperty
  a_hw_set: assert property (p_hw_set) else $error("request did not set flag");
  property p_hw_wins;
    $rose(timer_a_i) && w0 && !wdata_i[3] ##1 !w0 ##1 r0 |=> rdata_o[3];
  endproperty
  a_hw_wins: assert property (p_hw_wins) else $error("clear beat hardware set");
  property p_pending_read;
    rd_i && addr_i == `OFS_PENDING |=> rdata_o == {15'h0, $past(irq_o)};
  endproperty
  a_pending_read: assert property (p_pending_read) else $error("summary read differs from irq");
endmodule
bind interrupt_flag_status_bank flag_bank_properties props_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_a_i(timer_a_i),
  .pending_o(pending_o), .irq_o(irq_o));

// ==== verif/periph_model.sv ====
/* far side: peripheral request lines, one-cycle events or held levels.
   assumes fire_i changes just after rising edges. */
`timescale 1ns/100ps
module periph_model (
  input wire logic clk_i,
  input wire logic [27:0] fire_i,
  input wire logic hold_i,
  output logic [27:0] line_o
);
  initial line_o = 28'h0000000;
  // an event line drops again after one cycle unless held
  always @(posedge clk_i) begin
    line_o <= fire_i | (hold_i ? line_o : 28'h0000000);
  end
endmodule

// ==== verif/tb_top.sv ====
/* self-checking bench of the flag bank against an integer model.
   assumes cfg header and package are compiled first. */
`timescale 1ns/100ps
`include "irq_flag_bank_cfg.svh"
module tb_top import irq_flag_bank_pkg::*; ;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic hold = 1'b0;
  logic irq_o;
  reg_addr_t addr_i = 8'h00;
  reg_word_t wdata_i = 16'h0000;
  reg_word_t rdata_o;
  logic [27:0] fire = 28'h0000000;
  logic [27:0] ln;
  logic [2:0] inv = 3'h0;
  flag_vec_t pending_o;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int posn[28] = '{15, 13, 12, 11, 10, 9, 8, 7, 6, 5, 3, 2, 1, 31, 30, 28, 27, 25, 19, 18, 17, 16, 37, 33, 32, 0, 20, 29};
  int impl[$] = '{`IMPL_FLAGS0, `IMPL_FLAGS1, `IMPL_FLAGS2};
  int mf[3] = '{0, 0, 0};
  int men[3] = '{0, 0, 0};
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  periph_model periph_model_i (.clk_i(clk_i), .fire_i(fire), .hold_i(hold), .line_o(ln));
  interrupt_flag_status_bank interrupt_flag_status_bank_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .memory_op_done_i(ln[0]),
    .conversion_done_i(ln[1]), .serial_a_tx_i(ln[2]), .serial_a_rx_i(ln[3]), .sync_serial_a_event_i(ln[4]),
    .sync_serial_a_fault_i(ln[5]), .timer_c_i(ln[6]), .timer_b_i(ln[7]), .compare_ch_b_i(ln[8]),
    .capture_ch_b_i(ln[9]), .timer_a_i(ln[10]), .compare_ch_a_i(ln[11]), .capture_ch_a_i(ln[12]),
    .serial_b_tx_i(ln[13]), .serial_b_rx_i(ln[14]), .timer_e_i(ln[15]), .timer_d_i(ln[16]),
    .compare_ch_c_i(ln[17]), .pin_change_i(ln[18]), .comparator_i(ln[19]), .two_wire_a_master_i(ln[20]),
    .two_wire_a_slave_i(ln[21]), .capture_ch_c_i(ln[22]), .sync_serial_b_event_i(ln[23]),
    .sync_serial_b_fault_i(ln[24]), .ext_pin_a_i(ln[25] ^ inv[0]), .ext_pin_b_i(ln[26] ^ inv[1]),
    .ext_pin_c_i(ln[27] ^ inv[2]), .pending_o(pending_o), .irq_o(irq_o));
  function automatic flag_vec_t pend();
    pend = {16'(mf[2] & men[2]), 16'(mf[1] & men[1]), 16'(mf[0] & men[0])};
  endfunction
  function automatic void mset(input int p);
    mf[p / 16] |= 1 << (p % 16);
  endfunction
  task automatic chk(input flag_vec_t got, input flag_vec_t exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input int d);
    @(posedge clk_i);
    addr_i <= 8'(a);
    wdata_i <= 16'(d);
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input int a, input int e);
    @(posedge clk_i);
    addr_i <= 8'(a);
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(48'(rdata_o), 48'(e));
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    fire <= 28'(1) << i;
    @(posedge clk_i);
    fire <= 28'h0000000;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    int d;
    void'($urandom(32'h7dc682a3));
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 8; k++) rd(4 * k, 0);
    $display("reset values done");
    for (int k = 0; k < 3; k++) begin
      d = $urandom();
      wr(4 * k, d);
      mf[k] = d & impl[k];
      rd(4 * k, mf[k]);
      d = $urandom();
      wr(12 + 4 * k, d);
      men[k] = d & impl[k];
      rd(12 + 4 * k, men[k]);
    end
    @(negedge clk_i);
    chk(pending_o, pend());
    wr(`OFS_PENDING, 16'hffff);
    rd(`OFS_PENDING, pend() != 48'h0);
    wr(8'h20, 16'hffff);
    rd(8'h20, 0);
    for (int k = 0; k < 3; k++) wr(4 * k, 0);
    for (int k = 0; k < 3; k++) wr(12 + 4 * k, 16'hffff);
    mf = '{0, 0, 0};
    foreach (men[k]) men[k] = impl[k];
    @(negedge clk_i);
    chk(48'(irq_o), 48'h0);
    $display("register access done");
    for (int i = 0; i < 28; i++) begin
      pulse(i);
      repeat (4) @(posedge clk_i);
      mset(posn[i]);
      @(negedge clk_i);
      chk(pending_o, pend());
    end
    for (int k = 0; k < 3; k++) rd(4 * k, mf[k]);
    rd(`OFS_PENDING, 1);
    $display("event mapping done");
    for (int k = 0; k < 3; k++) wr(12 + 4 * k, 0);
    men = '{0, 0, 0};
    @(negedge clk_i);
    chk(48'(irq_o), 48'h0);
    rd(`OFS_FLAGS1, mf[1]);
    for (int k = 0; k < 3; k++) wr(12 + 4 * k, 16'hffff);
    foreach (men[k]) men[k] = impl[k];
    $display("disabled sources done");
    for (int k = 0; k < 3; k++) wr(4 * k, 0);
    mf = '{0, 0, 0};
    hold <= 1'b1;
    pulse(10);
    wr(`OFS_FLAGS0, 0);
    repeat (3) @(posedge clk_i);
    rd(`OFS_FLAGS0, 0);
    hold <= 1'b0;
    repeat (2) @(posedge clk_i);
    fire <= 28'(1) << 10;
    @(posedge clk_i);
    fire <= 28'h0000000;
    addr_i <= `OFS_FLAGS0;
    wdata_i <= 16'h0000;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    mset(3);
    rd(`OFS_FLAGS0, mf[0]);
    $display("held line and clear race done");
    wr(`OFS_POLARITY, 16'hffff);
    rd(`OFS_POLARITY, 7);
    @(posedge clk_i);
    inv <= 3'h7;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk(pending_o, pend());
    pulse(25);
    pulse(26);
    pulse(27);
    repeat (4) @(posedge clk_i);
    mset(0);
    mset(20);
    mset(29);
    @(negedge clk_i);
    chk(pending_o, pend());
    $display("pin polarity done");
    // pins back low, so the rising default polarity sees no edge at release
    @(posedge clk_i);
    inv <= 3'h0;
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    mf = '{0, 0, 0};
    men = '{0, 0, 0};
    for (int k = 0; k < 3; k++) rd(4 * k, 0);
    rd(`OFS_POLARITY, 0);
    chk(pending_o, pend());
    $display("second reset done");
    complete_run();
  end
endmodule
